//--- src/sfm_stream_to_mm_buffer.sv
// Stream sink to memory-mapped read buffer with status slave
module sfm_stream_to_mm_buffer (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [sfm_pkg::DATA_W-1:0] snk_data,
  input wire logic snk_valid,
  output logic snk_ready,
  input wire logic snk_packet_first_flag,
  input wire logic snk_packet_last_flag,
  input wire logic [sfm_pkg::EMPTY_W-1:0] snk_empty,
  input wire logic [sfm_pkg::CHANNEL_W-1:0] snk_channel,
  input wire logic [sfm_pkg::ERROR_W-1:0] snk_error,
  input wire logic [sfm_pkg::RD_ADDR_W-1:0] rd_address,
  input wire logic rd_read,
  output logic [sfm_pkg::DATA_W-1:0] rd_readdata,
  output logic rd_readdatavalid,
  output logic rd_waitrequest,
  input wire logic [sfm_pkg::ST_ADDR_W-1:0] st_address,
  input wire logic st_read,
  input wire logic st_write,
  input wire logic [sfm_pkg::DATA_W-1:0] st_writedata,
  output logic [sfm_pkg::DATA_W-1:0] st_readdata,
  output logic st_readdatavalid,
  output logic st_irq
);
  import sfm_pkg::*;

  // ----------------------------------------
  // Constants at the widths they meet
  // ----------------------------------------
  localparam logic [LVL_W-1:0] USABLE_C = LVL_W'(USABLE);
  localparam logic [DATA_W-1:0] AF_MAX_W = DATA_W'(AF_DEFAULT);
  localparam logic [DATA_W-1:0] THR_MIN_W = DATA_W'(THR_MIN);
  localparam logic [LVL_W-1:0] AF_RESET = LVL_W'(AF_DEFAULT);
  localparam logic [LVL_W-1:0] AE_RESET = LVL_W'(AE_DEFAULT);
  localparam logic [LVL_W-1:0] THR_MIN_C = LVL_W'(THR_MIN);

  // ----------------------------------------
  // Sink side: lane reorder and packing
  // ----------------------------------------
  logic [DATA_W-1:0] lanes_swapped;
  logic [INFO_W-1:0] push_info;
  logic [ENTRY_W-1:0] push_entry;
  logic fifo_in_ready;
  logic overflow_pulse;

  // The stream carries its first symbol in the top lane; the read word
  // wants symbol 0 in the bottom byte, so lanes are mirrored
  for (genvar i = 0; i < SYMBOLS_PER_BEAT; i++) begin : g_lane
    assign lanes_swapped[i*SYMBOL_SLOT_W +: SYMBOL_SLOT_W] =
      snk_data[(SYMBOLS_PER_BEAT-1-i)*SYMBOL_SLOT_W +: SYMBOL_SLOT_W]; // [R2] [R6] [R22]
  end

  // Packet fields only stored when packet mode is on
  assign push_info = PACKET_MODE ?
    {snk_error, snk_channel, snk_empty, snk_packet_last_flag, snk_packet_first_flag} :
    '0; // [R21] [R10]
  assign push_entry = {push_info, lanes_swapped};

  // Without backpressure the sink always looks ready and excess beats drop
  assign snk_ready = BACKPRESSURE ? fifo_in_ready : 1'b1; // [R3] [R18]
  // Overflow only means something when beats can be dropped
  assign overflow_pulse = snk_valid & ~fifo_in_ready & ~BACKPRESSURE; // [R23]

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [ENTRY_W-1:0] pop_entry;
  logic fifo_out_valid;
  logic fifo_out_ready;
  logic [LVL_W-1:0] fill_level;

  // Registers only; the embedded-memory choice maps onto the same store
  sfm_fifo #(
    .WIDTH(ENTRY_W),
    .DEPTH(DEPTH),
    .CAP(USABLE)
  ) u_store (
    .ref_clk(ref_clk),
    .rst(rst),
    .in_data(push_entry),
    .in_valid(snk_valid),
    .in_ready(fifo_in_ready),
    .out_data(pop_entry),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .level(fill_level) // Single clock: level read in its own domain [R28]
  ); // [R17] [R27] [R13]

  // ----------------------------------------
  // Read slave decode
  // ----------------------------------------
  wire rd_sel_data = rd_read & (rd_address == RD_OFS_DATA);
  wire rd_sel_pkt = rd_read & (rd_address == RD_OFS_PKT);
  wire rd_accept = rd_read & ~rd_waitrequest;
  wire rd_pop = rd_sel_data & fifo_out_valid;
  wire underflow_pulse = rd_sel_data & ~fifo_out_valid & ~BACKPRESSURE; // [R23]

  // Waitrequest only on data reads of an empty buffer
  assign rd_waitrequest = BACKPRESSURE & rd_sel_data & ~fifo_out_valid; // [R4] [R18]
  assign fifo_out_ready = rd_sel_data; // [R5]

  // ----------------------------------------
  // Packet status of the last popped entry
  // ----------------------------------------
  logic [INFO_W-1:0] info_q;
  logic [INFO_W-1:0] info_d;
  logic [ERROR_W-1:0] info_err;
  logic [CHANNEL_W-1:0] info_chan;
  logic [EMPTY_W-1:0] info_empty;
  logic info_last;
  logic info_first;
  logic [DATA_W-1:0] pkt_word;

  assign info_d = (PACKET_MODE && rd_pop) ? pop_entry[ENTRY_W-1:DATA_W] : info_q; // [R7]
  assign {info_err, info_chan, info_empty, info_last, info_first} = info_q;
  assign pkt_word = (DATA_W'(info_err) << PS_ERR_LO) |
                    (DATA_W'(info_chan) << PS_CHAN_LO) |
                    (DATA_W'(info_empty) << PS_EMPTY_LO) |
                    (DATA_W'(info_last) << PS_LAST_BIT) |
                    (DATA_W'(info_first) << PS_FIRST_BIT); // [R9]

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      info_q <= '0;
    end else begin
      info_q <= info_d;
    end
  end

  // ----------------------------------------
  // Read data return
  // ----------------------------------------
  logic [DATA_W-1:0] rd_data_q;
  logic [DATA_W-1:0] rd_data_d;
  logic rd_valid_q;

  // Offset 1 never pops; an underflowing read returns zero
  assign rd_data_d = rd_pop ? pop_entry[DATA_W-1:0] :
                     rd_sel_pkt ? pkt_word :
                     '0; // [R8] [R20]
  assign rd_readdata = rd_data_q;
  assign rd_readdatavalid = rd_valid_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_accept;
      if (rd_accept) begin
        rd_data_q <= rd_data_d;
      end
    end
  end

  // ----------------------------------------
  // Thresholds
  // ----------------------------------------
  logic [LVL_W-1:0] af_q;
  logic [LVL_W-1:0] ae_q;
  logic [LVL_W-1:0] thr_clamped;

  // Both thresholds share one clamp range, one up to the high default
  assign thr_clamped = (st_writedata < THR_MIN_W) ? THR_MIN_C :
                       (st_writedata > AF_MAX_W) ? AF_RESET :
                       st_writedata[LVL_W-1:0]; // [R26]

  wire st_wr_af = st_write & (st_address == ST_OFS_ALMOSTFULL);
  wire st_wr_ae = st_write & (st_address == ST_OFS_ALMOSTEMPTY);
  wire st_wr_ev = st_write & (st_address == ST_OFS_EVENT);
  wire st_wr_ie = st_write & (st_address == ST_OFS_IENABLE);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      af_q <= AF_RESET;
      ae_q <= AE_RESET;
    end else begin
      if (st_wr_af) begin
        af_q <= thr_clamped;
      end
      if (st_wr_ae) begin
        ae_q <= thr_clamped;
      end
    end
  end

  // ----------------------------------------
  // Instantaneous status
  // ----------------------------------------
  logic [STATUS_W-1:0] inst_status;

  assign inst_status[SB_FULL] = fill_level >= USABLE_C; // [R23] [R15]
  assign inst_status[SB_EMPTY] = fill_level == '0;
  assign inst_status[SB_ALMOSTFULL] = fill_level > af_q;
  assign inst_status[SB_ALMOSTEMPTY] = fill_level < ae_q;
  assign inst_status[SB_OVERFLOW] = overflow_pulse;
  assign inst_status[SB_UNDERFLOW] = underflow_pulse;

  // ----------------------------------------
  // Events and interrupt
  // ----------------------------------------
  logic [STATUS_W-1:0] event_flags;
  logic [STATUS_W-1:0] ienable_q;
  logic [STATUS_W-1:0] ev_clear;

  assign ev_clear = st_wr_ev ? st_writedata[STATUS_W-1:0] : '0;

  for (genvar b = 0; b < STATUS_W; b++) begin : g_event
    sfm_event_bit u_ev (
      .ref_clk(ref_clk),
      .rst(rst),
      .set(inst_status[b]),
      .clr(ev_clear[b]),
      .flag(event_flags[b])
    ); // [R24]
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ienable_q <= '0;
    end else if (st_wr_ie) begin
      ienable_q <= st_writedata[STATUS_W-1:0];
    end
  end

  // Level request: stays up until software clears the event or its enable bit
  assign st_irq = IRQ_ENABLE & (|(event_flags & ienable_q)); // [R25] [R16]

  // ----------------------------------------
  // Status slave read decode
  // ----------------------------------------
  logic [DATA_W-1:0] st_data_q;
  logic [DATA_W-1:0] st_data_d;
  logic st_valid_q;

  // One status slave serves both sides under a single clock
  always_comb begin
    st_data_d = '0;
    if (st_address == ST_OFS_LEVEL) begin
      st_data_d = DATA_W'(fill_level);
    end else if (st_address == ST_OFS_ISTATUS) begin
      st_data_d = DATA_W'(inst_status);
    end else if (st_address == ST_OFS_EVENT) begin
      st_data_d = DATA_W'(event_flags);
    end else if (st_address == ST_OFS_IENABLE) begin
      st_data_d = DATA_W'(ienable_q);
    end else if (st_address == ST_OFS_ALMOSTFULL) begin
      st_data_d = DATA_W'(af_q);
    end else if (st_address == ST_OFS_ALMOSTEMPTY) begin
      st_data_d = DATA_W'(ae_q);
    end
  end // [R11] [R12]

  assign st_readdata = st_data_q;
  assign st_readdatavalid = st_valid_q;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_data_q <= '0;
      st_valid_q <= 1'b0;
    end else begin
      st_valid_q <= st_read;
      if (st_read) begin
        st_data_q <= st_data_d;
      end
    end
  end
endmodule

//--- src/sfm_pkg.sv
// Shared constants for the stream to memory-mapped buffer
// Operation
// R1 - Read slave and stream sink data are both 32 bits wide
// R2 - Symbol byte lanes are reordered to match the read word convention
// R3 - Sink ready shows free space; a beat is taken only with valid
// R4 - Read of data waits while empty, released once data is present
// R5 - Reader pops by reading word offset 0 repeatedly
// R6 - Symbol 3 sits in the top byte, symbol 0 in the bottom byte
// R7 - Packet mode: a data read pops data and keeps its packet status
// R8 - Read at offset 1 returns last popped status without popping
// R9 - Status word: first bit 0, last bit 1, empty 3:2, channel 12:8, error 18:16
// R10 - Empty counts unused symbols in the final beat of a packet
// R11 - Status slaves offered; one suffices with a single clock
// R12 - Dual clock: each side and its status on its own clock; the code has only ref_clk
// R13 - Single clock: every data and status port shares one clock
// R14 - Depth is a parameter in beats, default 16
// R15 - Dual clock capacity is three entries below the depth
// R16 - Status ports are slaves, with an optional interrupt output
// R17 - Storage is selectable between registers and embedded memory; the code always uses registers
// R18 - Backpressure stalls full writes and empty reads
// R19 - Memory-mapped width is forced to 32 bits in this pairing
// R20 - Each access moves four bytes; narrow masters must mind flow
// R21 - Sink has symbol, beat, channel and error widths and packet mode
// R22 - Odd symbol widths take a slot rounded up to a power of two
// R23 - Status bits: full, empty, above high, below low, overflow, underflow
// R24 - Event bits stick when status is set, cleared by writing one
// R25 - Interrupt when an enabled event bit is set
// R26 - High threshold defaults by clock mode, writes clamped to one..default
// R27 - Strict arrival order; reset empties buffer and clears all status
// R28 - Cross-domain levels use synchronised gray pointers; the code has one clock and a binary level count
package sfm_pkg;
  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  localparam int DEPTH = 16; // [R14]
  localparam bit DUAL_CLOCK = 1'b0;
  localparam bit BACKPRESSURE = 1'b1;
  localparam bit PACKET_MODE = 1'b1;
  localparam bit IRQ_ENABLE = 1'b1;
  localparam bit STORAGE_EMBEDDED = 1'b1;
  localparam int BITS_PER_SYMBOL = 8;
  localparam int SYMBOLS_PER_BEAT = 4;
  localparam int CHANNEL_W = 5;
  localparam int ERROR_W = 3;
  localparam int EMPTY_W = 2;
  localparam int DATA_W = 32; // [R1] [R19]
  localparam int SYMBOL_SLOT_W = 1 << $clog2(BITS_PER_SYMBOL); // [R22]
  localparam int CROSS_MARGIN = 3;
  localparam int USABLE = DUAL_CLOCK ? DEPTH - CROSS_MARGIN : DEPTH; // [R15]
  localparam int LVL_W = $clog2(DEPTH + 1);
  localparam int AF_DEFAULT = DUAL_CLOCK ? DEPTH - 4 : DEPTH - 1; // [R26]
  localparam int AE_DEFAULT = 1;
  localparam int THR_MIN = 1;
  // ----------------------------------------
  // Entry and packet status layout
  // ----------------------------------------
  localparam int INFO_W = 2 + EMPTY_W + CHANNEL_W + ERROR_W;
  localparam int ENTRY_W = DATA_W + INFO_W;
  localparam int PS_FIRST_BIT = 0;
  localparam int PS_LAST_BIT = 1;
  localparam int PS_EMPTY_LO = 2;
  localparam int PS_CHAN_LO = 8;
  localparam int PS_ERR_LO = 16;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam int RD_ADDR_W = 1;
  localparam logic [RD_ADDR_W-1:0] RD_OFS_DATA = 1'h0; // [R5]
  localparam logic [RD_ADDR_W-1:0] RD_OFS_PKT = 1'h1;
  localparam int ST_ADDR_W = 3;
  localparam logic [ST_ADDR_W-1:0] ST_OFS_LEVEL = 3'h0;
  localparam logic [ST_ADDR_W-1:0] ST_OFS_ISTATUS = 3'h1;
  localparam logic [ST_ADDR_W-1:0] ST_OFS_EVENT = 3'h2;
  localparam logic [ST_ADDR_W-1:0] ST_OFS_IENABLE = 3'h3;
  localparam logic [ST_ADDR_W-1:0] ST_OFS_ALMOSTFULL = 3'h4;
  localparam logic [ST_ADDR_W-1:0] ST_OFS_ALMOSTEMPTY = 3'h5;
  // ----------------------------------------
  // Status bits
  // ----------------------------------------
  localparam int STATUS_W = 6;
  localparam int SB_FULL = 0;
  localparam int SB_EMPTY = 1;
  localparam int SB_ALMOSTFULL = 2;
  localparam int SB_ALMOSTEMPTY = 3;
  localparam int SB_OVERFLOW = 4;
  localparam int SB_UNDERFLOW = 5;
endpackage

//--- src/sfm_fifo.sv
// Flip-flop first-in first-out store with valid and ready on both sides
module sfm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CAP = DEPTH
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] CAP_C = CW'(CAP);
  localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0] wr_q;
  logic [PW-1:0] rd_q;
  logic [CW-1:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = cnt_q < CAP_C;
  assign out_valid = cnt_q != '0;
  assign out_data = mem_q[rd_q];
  assign level = cnt_q;
  // Pointers wrap at DEPTH so the store needs no power-of-two size
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == LAST_C) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == LAST_C) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

//--- src/sfm_event_bit.sv
// One sticky event flag, cleared by writing a one
module sfm_event_bit (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic set,
  input wire logic clr,
  output logic flag
);
  logic flag_q;
  logic flag_d;
  // Set beats a clear in the same cycle so no event is lost
  assign flag_d = set | (flag_q & ~clr); // [R24]
  assign flag = flag_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end
endmodule

//--- test/sfm_stream_to_mm_buffer_assertions.sv
// Port timing checker for the stream to memory-mapped buffer
module sfm_stream_to_mm_buffer_checker (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic snk_valid,
  input wire logic snk_ready,
  input wire logic [sfm_pkg::RD_ADDR_W-1:0] rd_address,
  input wire logic rd_read,
  input wire logic [sfm_pkg::DATA_W-1:0] rd_readdata,
  input wire logic rd_readdatavalid,
  input wire logic rd_waitrequest,
  input wire logic st_read,
  input wire logic st_readdatavalid
);
  timeunit 1ns;
  timeprecision 1ns;
  import sfm_pkg::*;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  a_wait_data_only: assert property (rd_waitrequest |-> rd_read && rd_address == RD_OFS_DATA)
    else $error("waitrequest without a data read");
  a_wait_holds: assert property ((rd_waitrequest && !snk_valid) ##1 (rd_read && rd_address == RD_OFS_DATA)
    |-> rd_waitrequest) else $error("waitrequest dropped while still empty");
  a_wait_release: assert property (rd_waitrequest && snk_valid && snk_ready |=> !rd_waitrequest)
    else $error("waitrequest held after a beat arrived");
  a_rdv_follows: assert property (rd_read && !rd_waitrequest |=> rd_readdatavalid)
    else $error("accepted read gave no data valid");
  a_rdv_cause: assert property (rd_readdatavalid |-> $past(rd_read && !rd_waitrequest))
    else $error("data valid without an accepted read");
  a_pkt_reserved: assert property (rd_read && !rd_waitrequest && rd_address == RD_OFS_PKT |=>
    rd_readdata[31:19] == 0 && rd_readdata[15:13] == 0 && rd_readdata[7:4] == 0)
    else $error("reserved packet status bits set");
  a_ready_after_pop: assert property (!snk_ready && rd_read && !rd_waitrequest && rd_address == RD_OFS_DATA
    |=> snk_ready) else $error("no ready after a pop from full");
  a_empty_ready: assert property (rd_waitrequest |-> snk_ready)
    else $error("sink refused while empty");
  a_st_answer: assert property (st_read |=> st_readdatavalid)
    else $error("status read gave no data valid");
  a_st_cause: assert property (st_readdatavalid |-> $past(st_read))
    else $error("status data valid without a read");
endmodule
bind sfm_stream_to_mm_buffer sfm_stream_to_mm_buffer_checker u_chk (.ref_clk, .rst, .snk_valid, .snk_ready,
  .rd_address, .rd_read, .rd_readdata, .rd_readdatavalid, .rd_waitrequest, .st_read, .st_readdatavalid);

//--- test/sfm_stream_source.sv
// Stream source model feeding beats into the buffer sink
module sfm_stream_source (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic stall,
  input wire logic snk_ready,
  output logic [31:0] snk_data,
  output logic snk_valid,
  output logic snk_packet_first_flag,
  output logic snk_packet_last_flag,
  output logic [1:0] snk_empty,
  output logic [4:0] snk_channel,
  output logic [2:0] snk_error
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Beat queue and drive
  // ----------------------------------------
  logic [43:0] beats_q[$];
  logic taken_q = 1'b0;
  initial begin
    snk_valid = 1'b0;
    {snk_packet_first_flag, snk_packet_last_flag, snk_empty, snk_channel, snk_error, snk_data} = '0;
  end
  task automatic send(input logic [43:0] beat);
    beats_q.push_back(beat);
  endtask
  always @(posedge ref_clk) taken_q <= snk_valid && snk_ready && !rst;
  always @(negedge ref_clk) begin
    if (taken_q) void'(beats_q.pop_front());
    // Offered beat held until taken; stall only delays a new one
    if (beats_q.size() > 0 && ((snk_valid && !taken_q) || !stall)) begin
      snk_valid = 1'b1;
      {snk_packet_first_flag, snk_packet_last_flag, snk_empty, snk_channel, snk_error, snk_data} = beats_q[0];
    end else begin
      snk_valid = 1'b0;
      // Released lines change, so a stale beat cannot pass as fresh
      {snk_packet_first_flag, snk_packet_last_flag, snk_empty, snk_channel, snk_error, snk_data} =
        ~{snk_packet_first_flag, snk_packet_last_flag, snk_empty, snk_channel, snk_error, snk_data};
    end
  end
endmodule

//--- test/sfm_stream_to_mm_buffer_tb_top.sv
// Self-checking bench of the stream to memory-mapped buffer
module sfm_stream_to_mm_buffer_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sfm_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic ref_clk = 1'b0, rst = 1'b1, stall = 1'b0, rd_read = 1'b0, st_read = 1'b0, st_write = 1'b0;
  logic [31:0] snk_data, rd_readdata, st_readdata, st_writedata = '0, seed = 32'h0000_6C92;
  logic snk_valid, snk_ready, snk_packet_first_flag, snk_packet_last_flag, rd_readdatavalid;
  logic rd_waitrequest, st_readdatavalid, st_irq;
  logic [1:0] snk_empty;
  logic [4:0] snk_channel;
  logic [2:0] snk_error, st_address = 3'h0;
  logic [0:0] rd_address = 1'h0;
  logic [43:0] exp_q[$];
  int err_count = 0, checks_done = 0, cycles = 0;
  sfm_stream_to_mm_buffer dut (.ref_clk, .rst, .snk_data, .snk_valid, .snk_ready, .snk_packet_first_flag,
    .snk_packet_last_flag, .snk_empty, .snk_channel, .snk_error, .rd_address, .rd_read, .rd_readdata,
    .rd_readdatavalid, .rd_waitrequest, .st_address, .st_read, .st_write, .st_writedata, .st_readdata,
    .st_readdatavalid, .st_irq);
  sfm_stream_source src (.ref_clk, .rst, .stall, .snk_ready, .snk_data, .snk_valid, .snk_packet_first_flag,
    .snk_packet_last_flag, .snk_empty, .snk_channel, .snk_error);
  always #25 ref_clk = ~ref_clk;
  always @(negedge ref_clk) stall <= ^xs();
  always @(posedge ref_clk) begin
    cycles++;
    // Whole run needs a few hundred cycles; this only cuts a hang
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [43:0] mk_beat();
    logic [31:0] r;
    r = xs();
    return {r[11:0], xs()};
  endfunction
  function automatic logic [31:0] swap(input logic [31:0] d);
    return {d[7:0], d[15:8], d[23:16], d[31:24]};
  endfunction
  function automatic logic [31:0] pkt(input logic [43:0] b);
    return {13'h0, b[34:32], 3'h0, b[39:35], 4'h0, b[41:40], b[42], b[43]};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      err_count++;
    end
  endtask
  task automatic rd(input logic [0:0] a, output logic [31:0] d, output int waits);
    logic w;
    rd_address = a;
    rd_read = 1'b1;
    waits = 0;
    do begin
      #20 w = rd_waitrequest;
      @(posedge ref_clk);
      waits++;
    end while (w !== 1'b0 && waits < 200);
    @(negedge ref_clk);
    chk(rd_readdatavalid, 1);
    d = rd_readdata;
    rd_read = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic st_acc(input logic wr, input logic [2:0] a, input logic [31:0] wd, output logic [31:0] d);
    st_address = a;
    st_write = wr;
    st_read = !wr;
    st_writedata = wd;
    @(negedge ref_clk);
    st_read = 1'b0;
    st_write = 1'b0;
    d = st_readdata;
    if (!wr) chk(st_readdatavalid, 1);
    @(negedge ref_clk);
  endtask
  task automatic pop_check();
    logic [31:0] d;
    logic [43:0] b;
    int w;
    rd(RD_OFS_DATA, d, w);
    b = exp_q.pop_front();
    chk(d, swap(b[31:0]));
    rd(RD_OFS_PKT, d, w);
    chk(d, pkt(b));
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    logic [43:0] b;
    int w, n;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    st_acc(0, ST_OFS_LEVEL, 0, d);
    chk(d, 0);
    st_acc(0, ST_OFS_ALMOSTFULL, 0, d);
    chk(d, 15);
    st_acc(0, ST_OFS_EVENT, 0, d);
    chk(d, 32'h0000_000A);
    st_acc(0, 3'h6, 0, d);
    chk(d, 0);
    fork
      rd(RD_OFS_DATA, d, w);
      begin
        repeat (3) @(negedge ref_clk);
        src.send({1'b1, 1'b1, 2'h3, 5'h1F, 3'h7, 32'h1122_3344});
      end
    join
    chk(d, 32'h4433_2211);
    chk(w > 3, 1);
    for (int i = 0; i < 2; i++) begin
      rd(RD_OFS_PKT, d, w);
      chk(d, 32'h0007_1F0F);
    end
    st_acc(0, ST_OFS_LEVEL, 0, d);
    chk(d, 0);
    for (int i = 0; i < 20; i++) begin
      b = mk_beat();
      exp_q.push_back(b);
      src.send(b);
    end
    n = 0;
    while (snk_ready !== 1'b0 && n < 200) begin
      @(negedge ref_clk);
      n++;
    end
    st_acc(0, ST_OFS_LEVEL, 0, d);
    chk(d, 16);
    chk(snk_ready, 0);
    st_acc(0, ST_OFS_ISTATUS, 0, d);
    chk(d, 32'h0000_0005);
    for (int i = 0; i < 20; i++) pop_check();
    st_acc(0, ST_OFS_ISTATUS, 0, d);
    chk(d, 32'h0000_000A);
    st_acc(0, ST_OFS_EVENT, 0, d);
    chk(d, 32'h0000_000F);
    st_acc(1, ST_OFS_EVENT, 5, d);
    st_acc(0, ST_OFS_EVENT, 0, d);
    chk(d, 32'h0000_000A);
    st_acc(1, ST_OFS_IENABLE, 1, d);
    chk(st_irq, 0);
    st_acc(1, ST_OFS_IENABLE, 2, d);
    chk(st_irq, 1);
    st_acc(1, ST_OFS_IENABLE, 0, d);
    chk(st_irq, 0);
    for (int i = 0; i < 4; i++) begin
      st_acc(1, i < 2 ? ST_OFS_ALMOSTFULL : ST_OFS_ALMOSTEMPTY, i[0] ? 32'd100 : 32'd0, d);
      st_acc(0, i < 2 ? ST_OFS_ALMOSTFULL : ST_OFS_ALMOSTEMPTY, 0, d);
      chk(d, i[0] ? 15 : 1);
    end
    finish_test();
  end
endmodule
